/* verilog/pci_arbiter.sv */
// Secondary bus arbiter with fairness, broken-master and toggle policies.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
`include "arb_params.svh"
module pci_arbiter (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bridge_req,
  input  wire logic [3:0]  ext_req_n,
  input  wire logic        frame_n,
  input  wire logic        irdy_n,
  output logic [4:0]       gnt_n,
  output logic             ext_arb_sel
);
  import arb_pkg::*;

  localparam arb_regs_t ST_RST = '{fsm: ARB_IDLE, cfg: `ARB_CFG_RST,
                                   gnt_n: 5'h1F, default: '0};

  arb_regs_t  st_ff;
  arb_regs_t  nx;
  logic [4:0] req_all;
  logic [4:0] cfg_en;
  logic [4:0] prio;
  logic [4:0] excl;
  logic [4:0] pend;
  logic [4:0] others;
  logic [4:0] own_hot;
  logic [7:0] fair_load;
  logic       ext_on;
  logic       tmo_en;
  logic       rfr_en;
  logic       tog_en;
  logic       own_req;
  logic       frame_fall;
  logic       bus_idle;
  logic       pick_valid;
  logic [2:0] pick_win;
  logic [31:0] stat_word;

  //////////////////////////////////////////////////////////////////////////
  // Configuration fields and derived request views.
  assign cfg_en    = st_ff.cfg[`ARB_EN_LSB +: 5];
  assign ext_on    = st_ff.cfg[`ARB_EXT_BIT];
  assign tmo_en    = st_ff.cfg[`ARB_TMO_BIT];
  assign rfr_en    = st_ff.cfg[`ARB_RFR_BIT];
  assign fair_load = st_ff.cfg[`ARB_FAIR_LSB +: 8];
  assign tog_en    = st_ff.cfg[`ARB_TOG_BIT];
  assign prio      = st_ff.cfg[`ARB_PRIO_LSB +: 5];
  // The bridge request is on this clock, so it needs no synchroniser.
  assign req_all   = {st_ff.req_s, bridge_req};
  assign excl      = st_ff.broken | st_ff.dead;
  assign pend      = req_all & cfg_en & ~excl;
  assign own_hot   = 5'h01 << st_ff.owner;
  assign others    = pend & ~own_hot;
  assign own_req   = req_all[st_ff.owner];
  assign frame_fall = st_ff.frm_s && !st_ff.frm_prev;
  assign bus_idle  = !st_ff.frm_s && !st_ff.irdy_s;

  assign stat_word = {12'h000, st_ff.owner, st_ff.fsm, st_ff.dead,
                      st_ff.broken, ~st_ff.gnt_n};

  arb_pick #(
    .N (5)
  ) u_pick (
    .pending (pend),
    .prio    (prio),
    .last    (st_ff.last),
    .valid   (pick_valid),
    .winner  (pick_win)
  );

  //////////////////////////////////////////////////////////////////////////
  // Next state: synchronisers, register slave, grant machine, broken state.
  always_comb
  begin
    nx = st_ff;
    // Pins cross in through two flops; only the second one is read.
    nx.req_m    = ~ext_req_n;
    nx.req_s    = st_ff.req_m;
    nx.frm_m    = ~frame_n;
    nx.frm_s    = st_ff.frm_m;
    nx.frm_prev = st_ff.frm_s;
    nx.irdy_m   = ~irdy_n;
    nx.irdy_s   = st_ff.irdy_m;

    // One wait state keeps read data and the answer straight from flops.
    nx.pready  = 1'b0;
    nx.pslverr = 1'b0;
    if (psel && penable && !st_ff.pready)
    begin
      nx.pready = 1'b1;
      if (paddr == `ARB_CFG_OFS)
        nx.prdata = st_ff.cfg;
      else if (paddr == `ARB_STAT_OFS)
        nx.prdata = stat_word;
      else
      begin
        nx.prdata  = 32'h0000_0000;
        nx.pslverr = 1'b1;
      end
    end
    if (psel && penable && st_ff.pready && pwrite && paddr == `ARB_CFG_OFS)
      nx.cfg = pwdata & `ARB_CFG_WMASK;

    unique case (st_ff.fsm)
      ARB_IDLE:
      begin
        nx.gnt_n = 5'h1F;
        if (!ext_on && pick_valid)
        begin
          nx.fsm     = ARB_GRANT;
          nx.owner   = pick_win;
          nx.last    = pick_win;
          nx.gnt_n   = ~(5'h01 << pick_win);
          nx.fair_cnt = fair_load;
          nx.tmo_cnt = 5'h00;
          nx.tog_cnt = 2'h0;
          nx.served  = st_ff.served | (5'h01 << pick_win);
        end
      end
      ARB_GRANT:
      begin
        if (ext_on || !own_req)
        begin
          nx.fsm   = ARB_IDLE;
          nx.gnt_n = 5'h1F;
        end
        else if (frame_fall)
        begin
          nx.fsm     = ARB_BUSY;
          nx.tog_cnt = tog_en ? 2'h1 : 2'h0;
        end
        else if (tmo_en && bus_idle)
        begin
          if (st_ff.tmo_cnt == `ARB_BMT_CYCLES - 5'h01)
          begin
            nx.broken[st_ff.owner] = 1'b1;
            nx.served = 5'h00;
            nx.fsm    = ARB_IDLE;
            nx.gnt_n  = 5'h1F;
          end
          else
            nx.tmo_cnt = st_ff.tmo_cnt + 5'h01;
        end
      end
      ARB_BUSY:
      begin
        if (st_ff.tog_cnt == `ARB_TOG_DELAY - 2'h1)
        begin
          nx.gnt_n   = 5'h1F;
          nx.tog_cnt = `ARB_TOG_DELAY;
        end
        else if (st_ff.tog_cnt == `ARB_TOG_DELAY)
        begin
          nx.gnt_n   = ~own_hot;
          nx.tog_cnt = 2'h0;
        end
        if (ext_on || !own_req)
        begin
          nx.fsm   = ARB_IDLE;
          nx.gnt_n = 5'h1F;
        end
        else if (fair_load != 8'h00 && |others)
        begin
          if (st_ff.fair_cnt == 8'h00)
          begin
            nx.fsm   = ARB_IDLE;
            nx.gnt_n = 5'h1F;
          end
          else
            nx.fair_cnt = st_ff.fair_cnt - 8'h01;
        end
      end
      default:
      begin
        nx.fsm   = ARB_IDLE;
        nx.gnt_n = 5'h1F;
      end
    endcase

    // A timed-out master stays excluded until refresh clears it once the others are served; with refresh off it goes dead once it drops its request.
    for (int i = 0; i < 5; i++)
    begin
      if (st_ff.broken[i] && !req_all[i] && !rfr_en)
        nx.dead[i] = 1'b1;
      if (rfr_en && st_ff.broken[i] && !st_ff.dead[i]
          && &(st_ff.served | ~cfg_en | excl | (5'h01 << i)))
        nx.broken[i] = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register; reset loads constants only.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= ST_RST;
    else
      st_ff <= nx;
  end

  assign prdata      = st_ff.prdata;
  assign pready      = st_ff.pready;
  assign pslverr     = st_ff.pslverr;
  assign gnt_n       = st_ff.gnt_n;
  assign ext_arb_sel = st_ff.cfg[`ARB_EXT_BIT];

  //////////////////////////////////////////////////////////////////////////
  // Checks on the grant policy.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_ext_quiet;
    ext_on |=> gnt_n == 5'h1F;
  endproperty
  a_ext_quiet: assert property (p_ext_quiet)
    else $error("grant driven while external arbiter selected");

  property p_reload;
    (st_ff.fsm == ARB_IDLE && nx.fsm == ARB_GRANT)
      |=> st_ff.fair_cnt == $past(fair_load) && st_ff.fsm == ARB_GRANT;
  endproperty
  a_reload: assert property (p_reload)
    else $error("fairness counter not reloaded on new grant");

  property p_hold_count;
    (st_ff.fsm == ARB_GRANT && !frame_fall) |=> $stable(st_ff.fair_cnt);
  endproperty
  a_hold_count: assert property (p_hold_count)
    else $error("fairness counter moved before frame fall");

  property p_fair_limit;
    (st_ff.fsm == ARB_BUSY && !ext_on && own_req && |others
     && fair_load != 8'h00 && st_ff.fair_cnt == 8'h00)
      |=> gnt_n == 5'h1F && st_ff.fsm == ARB_IDLE;
  endproperty
  a_fair_limit: assert property (p_fair_limit)
    else $error("grant kept past fairness count");

  property p_fair_zero;
    (st_ff.fsm == ARB_BUSY && !ext_on && own_req && fair_load == 8'h00
     && st_ff.tog_cnt == 2'h0) |=> !gnt_n[st_ff.owner];
  endproperty
  a_fair_zero: assert property (p_fair_zero)
    else $error("grant removed with zero fairness load");

  property p_no_toggle;
    (st_ff.fsm == ARB_BUSY && !ext_on && !tog_en && own_req && others == 5'h00
     && st_ff.tog_cnt == 2'h0) |=> !gnt_n[st_ff.owner];
  endproperty
  a_no_toggle: assert property (p_no_toggle)
    else $error("grant dropped during owned transaction");

  property p_toggle;
    (st_ff.fsm == ARB_GRANT && frame_fall && own_req && tog_en && !ext_on)
      |=> st_ff.fsm == ARB_BUSY && !gnt_n[st_ff.owner] ##1 gnt_n == 5'h1F;
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("grant toggle not at second clock after frame");

  property p_timeout;
    (st_ff.fsm == ARB_GRANT && tmo_en && bus_idle && own_req && !ext_on
     && !frame_fall && st_ff.tmo_cnt == 5'h0F)
      |=> st_ff.broken[st_ff.owner] && gnt_n == 5'h1F;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("broken master timeout did not fire at 16 clocks");

  property p_grant_enabled;
    (st_ff.fsm == ARB_IDLE && nx.fsm == ARB_GRANT) |-> cfg_en[pick_win];
  endproperty
  a_grant_enabled: assert property (p_grant_enabled)
    else $error("disabled requester granted");

  property p_grant_healthy;
    (st_ff.fsm == ARB_IDLE && nx.fsm == ARB_GRANT) |-> !excl[pick_win];
  endproperty
  a_grant_healthy: assert property (p_grant_healthy)
    else $error("broken requester granted");

  property p_prio_first;
    (st_ff.fsm == ARB_IDLE && nx.fsm == ARB_GRANT && |(pend & prio))
      |-> prio[pick_win];
  endproperty
  a_prio_first: assert property (p_prio_first)
    else $error("low priority granted over high");

endmodule

/* verilog/arb_params.svh */
// Offsets, field positions, reset values and counts of the bus arbiter.
// How it works
// - No refresh: broken master, once idle, excluded forever.
// - Refresh: broken master returns after others served.
// - Fairness load value bits 19:12, reset 08h.
// - Others requesting: grant held fairness-count cycles.
// - Fairness counter reloads on every new grant.
// - Counting starts only after next frame fall.
// - Load value zero: grant stays until request drops.
// - Toggle off: grant held through the transaction.
// - Toggle on: grant off one clock, two after frame.
// - Priority bits 22..26, one means high.
// - Priority reset: bridge high, masters one-four low.
// - Timeout on: 16 idle clocks unused grant breaks master.
// - Per-requester enable bit, reset one, gates arbitration.
// - External arbiter select disables all internal grants.
`ifndef ARB_PARAMS_SVH
`define ARB_PARAMS_SVH

`define ARB_NREQ       5
`define ARB_CFG_OFS    12'h048
`define ARB_STAT_OFS   12'h080
`define ARB_EN_LSB     0
`define ARB_EXT_BIT    9
`define ARB_TMO_BIT    10
`define ARB_RFR_BIT    11
`define ARB_FAIR_LSB   12
`define ARB_TOG_BIT    20
`define ARB_PRIO_LSB   22
`define ARB_CFG_RST    32'h0040_801F
`define ARB_CFG_WMASK  32'h07DF_FE1F
`define ARB_BMT_CYCLES 5'h10
`define ARB_TOG_DELAY  2'h2
`define ARB_ST_GNT_LSB 0
`define ARB_ST_BRK_LSB 5
`define ARB_ST_DEAD_LSB 10
`define ARB_ST_FSM_LSB 15
`define ARB_ST_OWN_LSB 17

`endif

/* verilog/arb_pkg.sv */
// Types shared by the bus arbiter modules.
`include "arb_params.svh"
package arb_pkg;

  // Gray coded along idle, grant, busy.
  typedef enum logic [1:0]
  {
    ARB_IDLE  = 2'b00,
    ARB_GRANT = 2'b01,
    ARB_BUSY  = 2'b11
  } arb_state_t;

  // Whole state of the arbiter top.
  typedef struct packed {
    arb_state_t            fsm;
    logic [2:0]            owner;
    logic [2:0]            last;
    logic [`ARB_NREQ-1:0]  gnt_n;
    logic [7:0]            fair_cnt;
    logic [4:0]            tmo_cnt;
    logic [1:0]            tog_cnt;
    logic [`ARB_NREQ-1:0]  broken;
    logic [`ARB_NREQ-1:0]  dead;
    logic [`ARB_NREQ-1:0]  served;
    logic [`ARB_NREQ-2:0]  req_m;
    logic [`ARB_NREQ-2:0]  req_s;
    logic                  frm_m;
    logic                  frm_s;
    logic                  frm_prev;
    logic                  irdy_m;
    logic                  irdy_s;
    logic [31:0]           cfg;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
  } arb_regs_t;

endpackage

/* verilog/arb_pick.sv */
// Two-level round-robin winner selection for the bus arbiter.
`timescale 1ns/10ps
module arb_pick #(
  parameter int N = 5
) (
  input  wire logic [N-1:0] pending,
  input  wire logic [N-1:0] prio,
  input  wire logic [2:0]   last,
  output logic              valid,
  output logic [2:0]        winner
);

  // Nearest set bit after the last owner, wrapping; bit 3 flags a find.
  function automatic logic [3:0] rr_pick(input logic [N-1:0] m, input logic [2:0] from);
    logic [3:0] res;
    int         idx;
    res = 4'h0;
    for (int k = N; k >= 1; k--)
    begin
      idx = (int'(from) + k) % N;
      if (m[idx])
        res = {1'b1, 3'(idx)};
    end
    return res;
  endfunction

  logic [3:0] hi;
  logic [3:0] lo;

  //////////////////////////////////////////////////////////////////////////
  // priority then rotation
  always_comb
  begin
    hi     = rr_pick(pending & prio, last);
    lo     = rr_pick(pending & ~prio, last);
    valid  = hi[3] | lo[3];
    winner = hi[3] ? hi[2:0] : lo[2:0];
  end

endmodule

/* sim/pci_masters.sv */
// Behavioural bus masters facing the arbiter; index 0 is the bridge's own port.
`timescale 1ns/10ps
module pci_masters (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [4:0] gnt_n,
  input  wire logic [4:0] want,
  input  wire logic [4:0] lazy,
  input  wire logic [7:0] len,
  output logic            bridge_req,
  output logic [3:0]      ext_req_n,
  output logic            frame_n,
  output logic            irdy_n
);
  logic [7:0] cnt;

  assign bridge_req = want[0];
  assign ext_req_n  = ~want[4:1];

  ////////////////////////////////////////////////////////////////////////////////
  // One shared bus: a granted, willing master starts a frame on an idle bus.
  // A lazy master never starts one, which is how a broken master is staged.
  // Released lines show the pull-up level, never a held value.
  // Prompt frame start.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt     <= 8'h00;
      frame_n <= 1'b1;
      irdy_n  <= 1'b1;
    end
    else if (cnt > 8'h01)
      cnt <= cnt - 8'h01;
    else if (cnt == 8'h01)
    begin
      cnt     <= 8'h00;
      frame_n <= 1'b1;
    end
    else if (!irdy_n)
      irdy_n <= 1'b1;
    else if (|(~gnt_n & want & ~lazy))
    begin
      cnt     <= len;
      frame_n <= 1'b0;
      irdy_n  <= 1'b0;
    end
  end
endmodule

/* sim/pci_bus_arbiter_policy_tb.sv */
// Self-checking bench of the bus arbiter against behavioural bus masters.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module pci_bus_arbiter_policy_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_arb_sel;
  logic        bridge_req, frame_n, irdy_n, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  gnt_n, want, lazy;
  logic [3:0]  ext_req_n;
  logic [7:0]  len;
  int          n_fail, comparisons, lo, rises, gap, idx, lo_a;

  // Bus clock, 50 ns period.
  always #25 pclk = ~pclk;

  pci_arbiter u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bridge_req(bridge_req), .ext_req_n(ext_req_n), .frame_n(frame_n),
    .irdy_n(irdy_n), .gnt_n(gnt_n), .ext_arb_sel(ext_arb_sel));

  pci_masters u_masters (.pclk(pclk), .presetn(presetn), .gnt_n(gnt_n), .want(want),
    .lazy(lazy), .len(len), .bridge_req(bridge_req), .ext_req_n(ext_req_n),
    .frame_n(frame_n), .irdy_n(irdy_n));

  ////////////////////////////////////////////////////////////////////////////////
  // One APB transfer; request held until the rising edge that samples pready high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd  = prdata;
    err = pslverr;
    `CHK("pready", 1'b1, pready)
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits, bounded, for a grant pattern other than idle and old.
  task automatic wait_new(input logic [4:0] old);
    int k;
    k = 0;
    do
    begin
      @(negedge pclk);
      k++;
    end
    while ((gnt_n === 5'h1F || gnt_n === old) && k < 80);
    `CHK("grant_wait", 1'b1, k < 80)
  endtask

  // Watches one grant line: low cycles of the first grant only, so later re-grants
  // do not blur the hold time, rises, and high cycles after the first low.
  task automatic watch(input int n, input int i);
    logic p;
    lo    = 0;
    rises = 0;
    gap   = 0;
    p     = 1'b1;
    repeat (n)
    begin
      @(negedge pclk);
      if (gnt_n[i] === 1'b0)
      begin
        if (rises == 0)
          lo++;
      end
      else if (lo > 0)
        gap++;
      if (p === 1'b0 && gnt_n[i] === 1'b1)
        rises++;
      p = gnt_n[i];
    end
  endtask

  // Waits, bounded, until grants and bus are idle, so tests do not overlap.
  task automatic settle();
    int k;
    k = 0;
    while ((gnt_n !== 5'h1F || frame_n !== 1'b1 || irdy_n !== 1'b1) && k < 80)
    begin
      @(negedge pclk);
      k++;
    end
    `CHK("settle", 1'b1, k < 80)
    repeat (4) @(negedge pclk);
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog; the whole run needs a few hundred cycles.
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    $display("Error watchdog expected finish seen timeout");
    print_verdict();
  end

  // Main sequence of tests.
  initial
  begin
    pclk    = 1'b0;
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    want    = 5'h00;
    lazy    = 5'h00;
    len     = 8'h04;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h048, 32'h0);
    `CHK("cfg_reset", 32'h0040801F, rd)
    `CHK("fair_reset", 8'h08, rd[19:12])
    `CHK("en_reset", 5'h1F, rd[4:0])
    `CHK("tog_reset", 1'b0, rd[20])
    apb(1'b0, 12'h04C, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    apb(1'b1, 12'h048, 32'hFFFFFFFF);
    apb(1'b0, 12'h048, 32'h0);
    `CHK("cfg_mask", 32'h07DFFE1F, rd)
    `CHK("ext_sel", 1'b1, ext_arb_sel)
    @(posedge pclk) want <= 5'b00010;
    watch(20, 1);
    `CHK("ext_no_grant", 0, lo)
    @(posedge pclk) want <= 5'b00000;
    $display("Test registers done");
    // High priority wins, then rotation after the last owner.
    apb(1'b1, 12'h048, 32'h0200801F);
    @(posedge pclk) want <= 5'b01010;
    wait_new(5'h1F);
    `CHK("prio_winner", 5'b10111, gnt_n)
    @(posedge pclk) want <= 5'b00110;
    wait_new(5'b10111);
    `CHK("rr_next", 5'b11101, gnt_n)
    wait_new(5'b11101);
    `CHK("fair_handover", 5'b11011, gnt_n)
    @(posedge pclk) want <= 5'b00000;
    settle();
    $display("Test priority done");
    // Hold time under contention must grow by the load difference.
    for (int l = 2; l <= 6; l += 4)
    begin
      apb(1'b1, 12'h048, 32'h0040001F | (32'(l) << 12));
      @(posedge pclk);
      len  <= 8'h1E;
      want <= 5'b00110;
      wait_new(5'h1F);
      idx = (gnt_n[1] === 1'b0) ? 1 : 2;
      watch(40, idx);
      `CHK("fair_start", 1'b1, lo >= l + 2)
      if (l == 2)
        lo_a = lo;
      @(posedge pclk) want <= 5'b00000;
      settle();
    end
    `CHK("fair_span", 4, lo - lo_a)
    $display("Test fairness done");
    // Load zero never withdraws; with toggling off there is no gap.
    apb(1'b1, 12'h048, 32'h0040001F);
    @(posedge pclk);
    len  <= 8'h14;
    want <= 5'b00110;
    wait_new(5'h1F);
    idx = (gnt_n[1] === 1'b0) ? 1 : 2;
    watch(60, idx);
    `CHK("zero_hold", 60, lo)
    `CHK("no_toggle", 0, rises)
    @(posedge pclk) want <= 5'b00000;
    repeat (8) @(negedge pclk);
    `CHK("released", 5'h1F, gnt_n)
    settle();
    $display("Test zero load done");
    // Toggling on: exactly one single-cycle gap in the grant.
    apb(1'b1, 12'h048, 32'h0050801F);
    @(posedge pclk);
    len  <= 8'h28;
    want <= 5'b00010;
    wait_new(5'h1F);
    watch(30, 1);
    `CHK("toggle_count", 1, rises)
    `CHK("toggle_gap", 1, gap)
    @(posedge pclk) want <= 5'b00000;
    settle();
    $display("Test toggle done");
    // A master that never starts a frame is cut off and classed broken.
    apb(1'b1, 12'h048, 32'h0040841F);
    @(posedge pclk);
    lazy <= 5'b10000;
    want <= 5'b10000;
    wait_new(5'h1F);
    watch(30, 4);
    `CHK("timeout_len", 1'b1, lo >= 15 && lo <= 17)
    apb(1'b0, 12'h080, 32'h0);
    `CHK("broken_flag", 1'b1, rd[9])
    @(posedge pclk) want <= 5'b00000;
    repeat (4) @(posedge pclk);
    want <= 5'b10000;
    watch(40, 4);
    `CHK("dead_no_grant", 0, lo)
    apb(1'b0, 12'h080, 32'h0);
    `CHK("dead_flag", 1'b1, rd[14])
    // Refresh on, only masters 1 and 3 enabled.
    apb(1'b1, 12'h048, 32'h00400C0A);
    @(posedge pclk);
    lazy <= 5'b01000;
    want <= 5'b01100;
    wait_new(5'h1F);
    `CHK("enable_gate", 5'b10111, gnt_n)
    watch(30, 3);
    @(posedge pclk) want <= 5'b00110;
    watch(40, 2);
    `CHK("disabled_idle", 0, lo)
    @(posedge pclk) want <= 5'b00000;
    settle();
    apb(1'b0, 12'h080, 32'h0);
    `CHK("refresh_clear", 1'b0, rd[8])
    $display("Test broken master done");
    print_verdict();
  end
endmodule
